// file: asc_core_model.sv
`timescale 1ns/1ps
// converter core: code names hold and input, goes stale after a while
module asc_core_model #(parameter int HOLD = 40) (
    input wire logic                  mclk,
    input wire asc_pkg::asc_core_type coreOut,
    output logic [9:0]                convResult
);
    logic [9:0] code_q = 10'h000; // code of the running conversion
    int         age_q  = 0;       // cycles since the strobe
    always_ff @(posedge mclk)
    begin
        age_q <= coreOut.convStart ? 0 : age_q + 1;
        if (coreOut.convStart)
            code_q <= coreOut.convSel ? {coreOut.ch1Pos, 6'h15}
                                      : {coreOut.ch0Pos, 6'h2A};
    end
    // a stale code must never pass for a fresh one
    assign convResult = (age_q < HOLD) ? code_q : ~code_q;
endmodule : asc_core_model

// file: asc_pkg.sv
package asc_pkg;
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - auto sampling restarts right after conversion ends
// - trigger code 111 ends sampling by counter
// - clock select zero uses system clock
// - conversion clock is cycle times prescaler plus one
// - each conversion lasts twelve conversion clocks
// - sample time counts conversion clocks, zero allowed
// - count 01, sequential: channels zero then one
// - count 00 uses channel zero only
// - each trigger ends sampling, starts conversion
// - results fill locations 0 to 15 in order
// - code 1111 interrupts after sixteen, then restarts
// - split bit zero gives one sixteen word buffer
// - half status bit shows which half fills
// - alternate bit zero always uses primary selects
// - select zero routes input zero and ground
// - scan enable overrides channel zero positive select
// - scan converts inputs upward, one per sequence
// - six scanned inputs fill 0-5, then restart
// - format 3 gives signed Q15 fraction
// - scan mask bits pick inputs, ascending order
// - conversions per interrupt is field plus one, sequences when simultaneous
// - interrupt reinitialises buffer and scan position

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
localparam logic [7:0] OFS_CH_SEL     = 8'h0C;
localparam logic [7:0] OFS_SCAN_SEL   = 8'h10;
localparam logic [7:0] OFS_STATUS     = 8'h14;
localparam logic [1:0] RESULT_REGION  = 2'h1;  // 0x40..0x7c
// field positions
localparam int ON_BIT = 15;
localparam int OUTPUT_FORMAT_LSB = 8;
localparam int TRIGGER_SOURCE_SELECT_LSB = 5;
localparam int SOFT_TRIG_BIT = 4;
localparam int AUTO_SAMPLE_ENABLE_BIT = 2;
localparam int SAMP_GO_BIT = 1;
localparam int SIMULTANEOUS_SAMPLE_ENABLE_BIT = 12;
localparam int SCAN_BIT = 10;
localparam int CHANNEL_COUNT_SELECT_LSB = 8;
localparam int HALF_BIT = 7;
localparam int CPI_LSB = 2;
localparam int SPLIT_BIT = 1;
localparam int ALT_BIT = 0;
localparam int CLKSRC_BIT = 15;
localparam int AUTO_SAMPLE_TIME_LSB = 8;
localparam int PRESC_LSB = 0;
localparam int POSA_LSB = 0;
localparam int NEGA_BIT = 7;
localparam int POSB_LSB = 8;
localparam int NEGB_BIT = 15;
localparam int CH1A_LSB = 16;
localparam int CH1B_LSB = 20;
localparam int IRQ_BIT = 0;
localparam int BUSY_BIT = 1;
// values after reset and writable masks
localparam logic [31:0] RST_WORD        = 32'h0000_0000;
localparam logic [31:0] MASK_CTRL_ONE   = 32'h0000_83E4;
localparam logic [31:0] MASK_CTRL_TWO   = 32'h0000_173F;
localparam logic [31:0] MASK_CTRL_THREE = 32'h0000_9FFF;
localparam logic [31:0] MASK_CH_SEL     = 32'h00FF_8F8F;
localparam logic [31:0] MASK_SCAN_SEL   = 32'h0000_FFFF;
// codes
localparam logic [1:0] RESP_OKAY   = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;
localparam logic [2:0] TRIG_SOFT   = 3'h0;
localparam logic [2:0] TRIG_AUTO   = 3'h7;
localparam logic [1:0] FMT_UINT    = 2'h0;
localparam logic [1:0] FMT_SINT    = 2'h1;
localparam logic [1:0] FMT_UFRAC   = 2'h2;
localparam logic [1:0] FMT_Q15     = 2'h3;
// conversion length in conversion clock periods
localparam logic [3:0] CONV_TAD_PERIODS = 4'hC;

typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT}
    asc_state_type;

// everything driven toward the sample-and-hold and converter core
typedef struct packed {
    logic [1:0] shSample;   // sample-and-hold 1/0 tracking
    logic       convStart;  // one-cycle pulse per conversion
    logic       convSel;    // hold being converted
    logic [3:0] ch0Pos;     // hold zero positive input
    logic       ch0Neg;     // hold zero negative: 0 = ground
    logic [3:0] ch1Pos;     // hold one positive input
} asc_core_type;

endpackage : asc_pkg

// file: asc_sequencer.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module asc_sequencer (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic               rcClkIn,
    input  wire logic               extTrigIn,
    input  wire logic [9:0]         convResult,
    output asc_pkg::asc_core_type   coreOut,
    output logic                    irqFlag
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// byte-lane merge of a write into a stored word
function automatic logic [31:0] mergeStrb(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
        if (strb[i])
            res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res & msk;
endfunction : mergeStrb

// lowest selected input at or above start, else lowest selected
function automatic logic [3:0] nextScan(input logic [15:0] mask,
    input logic [4:0] start);
    logic [3:0] pick;
    logic [3:0] low;
    logic       hit;
    pick = 4'h0;
    low  = 4'h0;
    hit  = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
        if (mask[i])
        begin
            low = 4'(i);
            if (5'(i) >= start)
            begin
                pick = 4'(i);
                hit  = 1'b1;
            end
        end
    end
    return hit ? pick : low;
endfunction : nextScan

// ten-bit code to the selected output format
function automatic logic [15:0] formatRes(input logic [9:0] r,
    input logic [1:0] fmt);
    logic [15:0] v;
    case (fmt)
        asc_pkg::FMT_UINT:  v = {6'h00, r};
        asc_pkg::FMT_SINT:  v = {{7{~r[9]}}, r[8:0]};
        asc_pkg::FMT_UFRAC: v = {r, 6'h00};
        asc_pkg::FMT_Q15:   v = {~r[9], r[8:0], 6'h00};
        default:            v = {6'h00, r};
    endcase
    return v;
endfunction : formatRes

// offset decode shared by the read and write paths
function automatic logic isMapped(input logic [7:0] a);
    return (a[7:6] == asc_pkg::RESULT_REGION) ||
           (a <= asc_pkg::OFS_STATUS && a[1:0] == 2'h0);
endfunction : isMapped

////////////////////////////////////////////////////////////////////////////////
// declarations
logic [2:0]  rcSync_q;      // rc clock: two sync stages and a history
logic [2:0]  trSync_q;      // external trigger, same arrangement
logic [7:0]  awAddr_q;      // held write address
logic [31:0] wData_q;       // held write data
logic [3:0]  wStrb_q;       // held write strobes
logic        awRdy_q;       // write address slot free
logic        wRdy_q;        // write data slot free
logic        bValid_q;
logic [1:0]  bResp_q;
logic        arRdy_q;
logic        rValid_q;
logic [31:0] rData_q;
logic [1:0]  rResp_q;
logic [31:0] ctl1_q;        // converter_control_one
logic [31:0] ctl2_q;        // converter_control_two
logic [31:0] ctl3_q;        // converter_control_three
logic [31:0] chSel_q;       // primary and secondary input selects
logic [31:0] scanSel_q;     // scan_input_select
logic        softTrig_q;    // software conversion trigger pulse
logic        sampGo_q;      // software sample start pulse
logic [15:0] results_q [16];
asc_pkg::asc_state_type state_q;
logic [7:0]  pre_q;         // prescaler phase
logic [3:0]  tadCnt_q;      // conversion clocks into this conversion
logic [4:0]  sampCnt_q;     // conversion clocks into sampling
logic        convSel_q;     // hold being converted
logic [3:0]  bufPtr_q;
logic        halfSel_q;     // buffer_half_status
logic [3:0]  convCnt_q;
logic [3:0]  scanPos_q;
logic        altPhase_q;    // 1 while the secondary selects are in use
logic        irqFlag_q;     // converter_irq_flag
asc_pkg::asc_core_type core_q;

////////////////////////////////////////////////////////////////////////////////
// control fields
logic        moduleOn;
logic        autoSample;
logic [2:0]  trigSrc;
logic [1:0]  outFmt;
logic [1:0]  chanCount;
logic        simSample;
logic        scanEn;
logic [3:0]  convPerIrq;
logic        splitMode;
logic        altEn;
logic        rcSel;
logic [4:0]  sampTime;
logic [7:0]  prescaler;
logic [15:0] scanMask;
assign moduleOn   = ctl1_q[asc_pkg::ON_BIT];
assign autoSample = ctl1_q[asc_pkg::AUTO_SAMPLE_ENABLE_BIT];
assign trigSrc    = ctl1_q[asc_pkg::TRIGGER_SOURCE_SELECT_LSB +: 3];
assign outFmt     = ctl1_q[asc_pkg::OUTPUT_FORMAT_LSB +: 2];
assign chanCount  = ctl2_q[asc_pkg::CHANNEL_COUNT_SELECT_LSB +: 2];
assign simSample  = ctl2_q[asc_pkg::SIMULTANEOUS_SAMPLE_ENABLE_BIT];
assign scanEn     = ctl2_q[asc_pkg::SCAN_BIT];
assign convPerIrq = ctl2_q[asc_pkg::CPI_LSB +: 4];
assign splitMode  = ctl2_q[asc_pkg::SPLIT_BIT];
assign altEn      = ctl2_q[asc_pkg::ALT_BIT];
assign rcSel      = ctl3_q[asc_pkg::CLKSRC_BIT];
assign sampTime   = ctl3_q[asc_pkg::AUTO_SAMPLE_TIME_LSB +: 5];
assign prescaler  = ctl3_q[asc_pkg::PRESC_LSB +: 8];
assign scanMask   = scanSel_q[15:0];

////////////////////////////////////////////////////////////////////////////////
// input synchronisers; only stage two and the history feed logic
always_ff @(posedge mclk)
begin
    if (rst)
    begin
        rcSync_q <= 3'h0;
        trSync_q <= 3'h0;
    end
    else
    begin
        rcSync_q <= {rcSync_q[1:0], rcClkIn};
        trSync_q <= {trSync_q[1:0], extTrigIn};
    end
end

logic rcEdge;
logic extEdge;
assign rcEdge  = rcSync_q[1] & ~rcSync_q[2];
assign extEdge = trSync_q[1] & ~trSync_q[2];

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel: address and data taken in either order
logic wrEn;
logic wrOk;
assign wrEn = ~awRdy_q & ~wRdy_q & ~bValid_q;
assign wrOk = isMapped(awAddr_q);

always_ff @(posedge mclk)
begin
    if (rst)
    begin
        awRdy_q  <= 1'b1;
        wRdy_q   <= 1'b1;
        bValid_q <= 1'b0;
        bResp_q  <= asc_pkg::RESP_OKAY;
        awAddr_q <= 8'h00;
        wData_q  <= 32'h0000_0000;
        wStrb_q  <= 4'h0;
    end
    else
    begin
        if (awvalid && awRdy_q)
        begin
            awAddr_q <= awaddr;
            awRdy_q  <= 1'b0;
        end
        if (wvalid && wRdy_q)
        begin
            wData_q <= wdata;
            wStrb_q <= wstrb;
            wRdy_q  <= 1'b0;
        end
        if (wrEn)
        begin
            bValid_q <= 1'b1;
            bResp_q  <= wrOk ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
        end
        else if (bValid_q && bready)
        begin
            // both slots reopen only once the response is taken
            bValid_q <= 1'b0;
            awRdy_q  <= 1'b1;
            wRdy_q   <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers; writes to the result region are dropped
logic wrCtl1;
logic irqClr;
assign wrCtl1 = wrEn && awAddr_q == asc_pkg::OFS_CTRL_ONE;
assign irqClr = wrEn && awAddr_q == asc_pkg::OFS_STATUS &&
                wStrb_q[0] && wData_q[asc_pkg::IRQ_BIT];

always_ff @(posedge mclk)
begin
    if (rst)
    begin
        ctl1_q    <= asc_pkg::RST_WORD;
        ctl2_q    <= asc_pkg::RST_WORD;
        ctl3_q    <= asc_pkg::RST_WORD;
        chSel_q   <= asc_pkg::RST_WORD;
        scanSel_q <= asc_pkg::RST_WORD;
    end
    else if (wrEn)
    begin
        case (awAddr_q)
            asc_pkg::OFS_CTRL_ONE:
                ctl1_q <= mergeStrb(ctl1_q, wData_q, wStrb_q,
                                    asc_pkg::MASK_CTRL_ONE);
            asc_pkg::OFS_CTRL_TWO:
                ctl2_q <= mergeStrb(ctl2_q, wData_q, wStrb_q,
                                    asc_pkg::MASK_CTRL_TWO);
            asc_pkg::OFS_CTRL_THREE:
                ctl3_q <= mergeStrb(ctl3_q, wData_q, wStrb_q,
                                    asc_pkg::MASK_CTRL_THREE);
            asc_pkg::OFS_CH_SEL:
                chSel_q <= mergeStrb(chSel_q, wData_q, wStrb_q,
                                     asc_pkg::MASK_CH_SEL);
            asc_pkg::OFS_SCAN_SEL:
                scanSel_q <= mergeStrb(scanSel_q, wData_q, wStrb_q,
                                       asc_pkg::MASK_SCAN_SEL);
            default: ;  // status handled below, results read only
        endcase
    end
end

// self-clearing command bits in control one, read back as zero
always_ff @(posedge mclk)
begin
    if (rst)
    begin
        softTrig_q <= 1'b0;
        sampGo_q   <= 1'b0;
    end
    else
    begin
        softTrig_q <= wrCtl1 && wStrb_q[0] &&
                      wData_q[asc_pkg::SOFT_TRIG_BIT];
        sampGo_q   <= wrCtl1 && wStrb_q[0] &&
                      wData_q[asc_pkg::SAMP_GO_BIT];
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel: data one cycle after the address is taken
logic [31:0] rdMux;
always_comb
begin
    rdMux = 32'h0000_0000;
    if (araddr[7:6] == asc_pkg::RESULT_REGION)
        rdMux = {16'h0000, results_q[araddr[5:2]]};
    else
    begin
        case (araddr)
            asc_pkg::OFS_CTRL_ONE:   rdMux = ctl1_q;
            asc_pkg::OFS_CTRL_TWO:
            begin
                rdMux = ctl2_q;
                rdMux[asc_pkg::HALF_BIT] = halfSel_q;
            end
            asc_pkg::OFS_CTRL_THREE: rdMux = ctl3_q;
            asc_pkg::OFS_CH_SEL:     rdMux = chSel_q;
            asc_pkg::OFS_SCAN_SEL:   rdMux = scanSel_q;
            asc_pkg::OFS_STATUS:
            begin
                rdMux[asc_pkg::IRQ_BIT]  = irqFlag_q;
                rdMux[asc_pkg::BUSY_BIT] = state_q != asc_pkg::SEQ_IDLE;
            end
            default: rdMux = 32'h0000_0000;
        endcase
    end
end

always_ff @(posedge mclk)
begin
    if (rst)
    begin
        arRdy_q  <= 1'b1;
        rValid_q <= 1'b0;
        rData_q  <= 32'h0000_0000;
        rResp_q  <= asc_pkg::RESP_OKAY;
    end
    else if (arvalid && arRdy_q)
    begin
        arRdy_q  <= 1'b0;
        rValid_q <= 1'b1;
        rData_q  <= rdMux;
        rResp_q  <= isMapped(araddr) ? asc_pkg::RESP_OKAY
                                     : asc_pkg::RESP_SLVERR;
    end
    else if (rValid_q && rready)
    begin
        rValid_q <= 1'b0;
        arRdy_q  <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencing decisions
logic srcTick;
logic tadTick;
logic lastChan;
logic convEnd;
logic trigHit;
logic seqTwo;
assign srcTick  = rcSel ? rcEdge : 1'b1;
assign tadTick  = srcTick && pre_q == prescaler;
assign lastChan = chanCount == 2'h0 || convSel_q;
assign seqTwo   = chanCount != 2'h0 && !simSample;
assign convEnd  = state_q == asc_pkg::SEQ_CONVERT && tadTick &&
                  tadCnt_q == asc_pkg::CONV_TAD_PERIODS - 4'h1;

always_comb
begin
    case (trigSrc)
        asc_pkg::TRIG_AUTO: trigHit = sampCnt_q >= sampTime;
        asc_pkg::TRIG_SOFT: trigHit = softTrig_q;
        default:            trigHit = extEdge;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// sample/convert state machine with the conversion clock divider;
// the divider restarts on each phase so a conversion is whole periods
always_ff @(posedge mclk)
begin
    if (rst || !moduleOn)
    begin
        state_q   <= asc_pkg::SEQ_IDLE;
        pre_q     <= 8'h00;
        tadCnt_q  <= 4'h0;
        sampCnt_q <= 5'h00;
        convSel_q <= 1'b0;
    end
    else
    begin
        pre_q <= (srcTick && tadTick) ? 8'h00
               : srcTick ? pre_q + 8'h01 : pre_q;
        case (state_q)
            asc_pkg::SEQ_IDLE:
            begin
                if (autoSample || sampGo_q)
                begin
                    state_q   <= asc_pkg::SEQ_SAMPLE;
                    pre_q     <= 8'h00;
                    sampCnt_q <= 5'h00;
                end
            end
            asc_pkg::SEQ_SAMPLE:
            begin
                if (tadTick && sampCnt_q != 5'h1F)
                    sampCnt_q <= sampCnt_q + 5'h01;
                if (trigHit)
                begin
                    state_q   <= asc_pkg::SEQ_CONVERT;
                    pre_q     <= 8'h00;
                    tadCnt_q  <= 4'h0;
                    convSel_q <= 1'b0;
                end
            end
            asc_pkg::SEQ_CONVERT:
            begin
                if (tadTick)
                    tadCnt_q <= tadCnt_q + 4'h1;
                if (convEnd && !lastChan)
                begin
                    // second hold converts straight after the first
                    convSel_q <= 1'b1;
                    tadCnt_q  <= 4'h0;
                    pre_q     <= 8'h00;
                end
                else if (convEnd)
                begin
                    state_q   <= autoSample ? asc_pkg::SEQ_SAMPLE
                                            : asc_pkg::SEQ_IDLE;
                    pre_q     <= 8'h00;
                    sampCnt_q <= 5'h00;
                    convSel_q <= 1'b0;
                end
            end
            default: state_q <= asc_pkg::SEQ_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// buffer position, scan position and conversion count
logic       countStep;
logic       hitCount;
logic [3:0] curScan;
logic [3:0] wrIdx;
assign curScan   = nextScan(scanMask, {1'b0, scanPos_q});
// simultaneous mode counts whole sequences, other modes every channel
assign countStep = convEnd && (seqTwo || lastChan);
assign hitCount  = countStep && convCnt_q == convPerIrq;
assign wrIdx     = splitMode ? {halfSel_q, bufPtr_q[2:0]}
                             : bufPtr_q;

always_ff @(posedge mclk)
begin
    if (rst || !moduleOn)
    begin
        bufPtr_q   <= 4'h0;
        halfSel_q  <= 1'b0;
        convCnt_q  <= 4'h0;
        scanPos_q  <= 4'h0;
        altPhase_q <= 1'b0;
    end
    else if (hitCount)
    begin
        // restart from the top of the sequence after each interrupt
        bufPtr_q   <= 4'h0;
        convCnt_q  <= 4'h0;
        scanPos_q  <= nextScan(scanMask, 5'h00);
        altPhase_q <= 1'b0;
        halfSel_q  <= splitMode & ~halfSel_q;
    end
    else
    begin
        if (countStep)
            convCnt_q <= convCnt_q + 4'h1;
        if (convEnd)
            bufPtr_q <= bufPtr_q + 4'h1;
        if (convEnd && lastChan)
        begin
            scanPos_q  <= nextScan(scanMask, 5'(curScan) + 5'h01);
            altPhase_q <= altEn & ~altPhase_q;
        end
    end
end

// result store; a word stays until it is overwritten
always_ff @(posedge mclk)
begin
    if (convEnd)
        results_q[wrIdx] <= formatRes(convResult, outFmt);
end

// interrupt flag: an arriving event beats a same-cycle clear
always_ff @(posedge mclk)
begin
    if (rst)
        irqFlag_q <= 1'b0;
    else
        irqFlag_q <= hitCount || (irqFlag_q && !irqClr);
end

////////////////////////////////////////////////////////////////////////////////
// drive to the analog core, registered so every pin comes off a flop
logic useAlt;
logic sampling;
logic launch;
assign useAlt   = altEn && altPhase_q;
assign sampling = state_q == asc_pkg::SEQ_SAMPLE;
assign launch   = (sampling && trigHit) || (convEnd && !lastChan);

always_ff @(posedge mclk)
begin
    if (rst)
        core_q <= '0;
    else
    begin
        core_q.shSample[0] <= sampling;
        // sequential hold one keeps tracking while hold zero converts
        core_q.shSample[1] <= chanCount != 2'h0 && (sampling ||
            (seqTwo && state_q == asc_pkg::SEQ_CONVERT && !convSel_q));
        core_q.convStart   <= launch && moduleOn;
        core_q.convSel     <= convSel_q || (convEnd && !lastChan);
        core_q.ch0Pos      <= scanEn ? curScan
            : useAlt ? chSel_q[asc_pkg::POSB_LSB +: 4]
                     : chSel_q[asc_pkg::POSA_LSB +: 4];
        core_q.ch0Neg      <= useAlt ? chSel_q[asc_pkg::NEGB_BIT]
                                     : chSel_q[asc_pkg::NEGA_BIT];
        core_q.ch1Pos      <= useAlt ? chSel_q[asc_pkg::CH1B_LSB +: 4]
                                     : chSel_q[asc_pkg::CH1A_LSB +: 4];
    end
end

assign awready = awRdy_q;
assign wready  = wRdy_q;
assign bvalid  = bValid_q;
assign bresp   = bResp_q;
assign arready = arRdy_q;
assign rvalid  = rValid_q;
assign rdata   = rData_q;
assign rresp   = rResp_q;
assign coreOut = core_q;
assign irqFlag = irqFlag_q;

endmodule : asc_sequencer

// file: asc_sequencer_sva.sv
`timescale 1ns/1ps
// port-level checks on the strobe, the flag and the bus answers
module asc_sequencer_sva (
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  awready,
    input wire logic                  wready,
    input wire logic                  arready,
    input wire logic                  bvalid,
    input wire logic                  bready,
    input wire logic                  rvalid,
    input wire logic                  rready,
    input wire asc_pkg::asc_core_type coreOut,
    input wire logic                  irqFlag
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic lastSel_q; // hold converted by the previous strobe
    always_ff @(posedge mclk)
    begin
        if (rst)
            lastSel_q <= 1'b1;
        else if (coreOut.convStart)
            lastSel_q <= coreOut.convSel;
    end
    a_strobe_gap: assert property (coreOut.convStart |=>
        !coreOut.convStart [*8]) else $error("strobe too soon");
    a_hold_order: assert property (coreOut.convStart &&
        coreOut.convSel |-> !lastSel_q) else $error("hold order");
    a_irq_sticky: assert property ($fell(irqFlag) |->
        $rose(bvalid)) else $error("flag dropped alone");
    a_irq_end: assert property ($rose(irqFlag) |->
        !coreOut.convStart) else $error("flag at strobe");
    a_b_stands: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped");
    a_r_stands: assert property (rvalid && !rready |=> rvalid)
        else $error("read answer dropped");
    a_w_refused: assert property (bvalid |-> !awready && !wready)
        else $error("write taken early");
    a_r_refused: assert property (rvalid |-> !arready)
        else $error("read taken early");
endmodule : asc_sequencer_sva
bind asc_sequencer asc_sequencer_sva u_asc_sequencer_sva (.mclk(mclk),
    .rst(rst), .awready(awready), .wready(wready), .arready(arready),
    .bvalid(bvalid), .bready(bready), .rvalid(rvalid), .rready(rready),
    .coreOut(coreOut), .irqFlag(irqFlag));

// file: tb.sv
`timescale 1ns/1ps
module tb;
    logic        mclk = '0, rst = '1, awvalid = '0, wvalid = '0;
    logic        bready = '0, arvalid = '0, rready = '0, awready, wready;
    logic        bvalid, arready, rvalid, irqFlag;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [15:0] mask = 16'h003F; // six inputs on the first scan
    logic [9:0]  convResult;
    logic [3:0]  pos;
    logic [1:0]  bresp, rresp, rs;
    int          bad_count = 0, cmp_count = 0, seed = 77;
    asc_pkg::asc_core_type coreOut;
    asc_sequencer u_asc_sequencer (.mclk(mclk), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rcClkIn(1'b0), .extTrigIn(1'b0),
        .convResult(convResult), .coreOut(coreOut), .irqFlag(irqFlag));
    asc_core_model u_asc_core_model (.mclk(mclk), .coreOut(coreOut),
        .convResult(convResult));
    initial forever #20 mclk = ~mclk;
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : check
    // one bus transfer; the edge first, so no signal moves twice at once
    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge mclk);
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        for (i = 0; i < 50 && !(bvalid || rvalid); i++)
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (arready)
                arvalid <= 1'b0;
            {rd, rs} = {rdata, rresp};
        end
        {bready, rready} <= 2'h0;
        bad_count += (i == 50);
        if (i == 50)
            report_and_stop();
    endtask : xfer
    // input taken by the k-th conversion of a scan: ascending set bits
    function automatic logic [3:0] nth(logic [15:0] m, int k);
        for (int b = 0; b < 16; b++)
            if (m[b] && k-- == 0)
                return b[3:0];
        return 4'h0;
    endfunction : nth
    task automatic run(logic [31:0] c2, logic [1:0] fm, int n);
        logic [9:0] c;
        int         i;
        pos = 4'($random(seed));
        xfer(1'b1, 8'h08, $random(seed) & 32'h0000_0301);
        xfer(1'b1, 8'h0C, ($random(seed) & 32'h00F0_8F00) |
             {12'h000, ~pos, 12'h000, pos});
        xfer(1'b1, 8'h10, {16'h0000, mask});
        xfer(1'b1, 8'h04, c2);
        xfer(1'b1, 8'h00, {16'h0000, 1'b1, 5'h00, fm, 8'hE4});
        for (i = 0; i < 3000 && irqFlag !== 1'b1; i++)
            @(posedge mclk);
        check("irq wait", 32'h0, 32'(i == 3000));
        if (i == 3000)
            report_and_stop();
        xfer(1'b0, 8'h14, 32'h0);
        check("irq held", 32'h1, 32'(rd[0]));
        xfer(1'b1, 8'h00, 32'h0);
        for (i = 0; i < n; i++)
        begin
            xfer(1'b0, 8'h40 + 8'(4 * i), 32'h0);
            c = (c2[8] && i[0]) ? {~pos, 6'h15} :
                {c2[10] ? nth(mask, i) : pos, 6'h2A};
            check("result", fm == 2'h3 ? {16'h0, ~c[9], c[8:0], 6'h00}
                  : {22'h0, c}, rd);
        end
        xfer(1'b1, 8'h14, 32'h1);
        check("irq cleared", 32'h0, 32'(irqFlag));
    endtask : run
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        run(32'h0000_003C, 2'h0, 16);
        run(32'h0000_010E, 2'h0, 4);
        repeat (2)
        begin
            run({21'h0, 1'b1, 4'h0, 4'($countones(mask) - 1), 2'h0}, 2'h3,
                $countones(mask));
            mask = 16'($random(seed) & 32'h0000_003F) | 16'h0001;
        end
        xfer(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'(asc_pkg::RESP_SLVERR), 32'(rs));
        report_and_stop();
    end
endmodule : tb
